// ===== verilog/e3rx_regs.vh
// register offsets, field positions, reset values for the e3 rx status bank
// assumes 32-bit classic wishbone, one register per aligned word
`ifndef E3RX_REGS_VH
`define E3RX_REGS_VH
// printed offsets are not all multiples of four: index = offset, byte addr = 4*index
`define E3RX_IDX_STATUS_ONE 8'h24
`define E3RX_IDX_STATUS_TWO 8'h26
`define E3RX_IDX_LATCH_ONE 8'h28
`define E3RX_IDX_LATCH_TWO 8'h2a
`define E3RX_IDX_IRQEN_ONE 8'h2c
`define E3RX_IDX_IRQEN_TWO 8'h2e
`define E3RX_IDX_FE_COUNT 8'h34
`define E3RX_IDX_CONTROL 8'h20
`define E3RX_IDX_GLOBAL_EN 8'h40
// status / latch one bit positions
`define E3RX_B_SIG_LOSS 0
`define E3RX_B_OUT_FRAME 1
`define E3RX_B_ALARM_SIG 2
`define E3RX_B_REMOTE_ALARM 3
`define E3RX_B_FRAME_LOSS 4
`define E3RX_B_ALIGN_CHANGE 5
`define E3RX_B_N_BIT 6
`define E3RX_B_A_BIT 7
`define E3RX_B_UNFRAMED_ONES 8
// latch two bit positions
`define E3RX_B_COUNT_NONZERO 0
`define E3RX_B_FRAMING_ERR 8
// control register fields
`define E3RX_B_CTYPE_LO 8
`define E3RX_B_CTYPE_HI 9
`define E3RX_B_COUNT_ALWAYS 10
// count type codes
`define E3RX_CT_OUT_FRAME 2'h0
`define E3RX_CT_FAS_BIT 2'h1
`define E3RX_CT_FAS_WORD 2'h2
// masks and resets
`define E3RX_LATCH_ONE_MASK 16'h01ff
`define E3RX_LATCH_TWO_MASK 16'h0101
`define E3RX_CONTROL_MASK 16'h0700
`define E3RX_RESET_16 16'h0000
`endif

// ===== verilog/e3rx_status_irq_bank.v
// e3 g.751 receive status, change latches, irq enables and framing error count
// assumes frame processor inputs are synchronous to ref_clk_in; the loss-of-signal pin is not
// Operation
// - status bit 1 shows the out-of-frame condition
// - status bit 0 follows the line loss-of-signal pin level
// - second status bit 0 is one while the error count is nonzero
// - latch bit 8 sets on any unframed-all-ones change
// - latch bits 7 and 6 set on a or n bit change
// - latch bit 5 sets on a changed frame alignment reload
// - latch bits 4..0 set on frame loss, remote, ais, oof, los changes
// - second latch bit 8 sets on each framing error
// - second latch bit 0 sets only on rising count-nonzero
// - latch, enable and per-port global enable together raise interrupt
// - second enables 8 and 0 gate framing-error and nonzero latches
// - framing error count is sixteen bits of error events
// - readable count refreshes only on performance-monitor update
// - count type selects oof, fas bit errors or fas word errors
// - qualification bit zero suppresses fas bit and fas word counting during oof or ais
`include "e3rx_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module e3rx_status_irq_bank #(
  parameter CNT_W = 16,
  parameter FAS_BITS_W = 4
) (
  input wire ref_clk_in,
  input wire nrst_in,
  // classic wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [9:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // frame processor conditions
  input wire line_signal_loss_input_in,
  input wire out_frame_in,
  input wire alarm_signal_in,
  input wire remote_alarm_in,
  input wire frame_loss_in,
  input wire unframed_all_ones_state_in,
  input wire integrated_a_bit_in,
  input wire integrated_n_bit_in,
  input wire alignment_reload_in,
  input wire alignment_differs_in,
  input wire framing_error_in,
  input wire [FAS_BITS_W-1:0] fas_bit_errors_in,
  input wire perf_monitor_update_in,
  output reg port_irq_out
);

  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // pin crossing: first stage read only by second
  reg los_meta_q;
  reg los_sync_q;
  reg [15:0] status_one_q;
  reg [15:0] latch_one_q;
  reg [15:0] latch_two_q;
  reg [15:0] irq_en_one_q;
  reg [15:0] irq_en_two_q;
  reg [15:0] control_q;
  reg global_en_q;
  reg [CNT_W-1:0] accum_q;
  reg [CNT_W-1:0] tally_q;
  reg nonzero_prev_q;
  reg [15:0] status_one_d;
  reg [CNT_W-1:0] accum_d;
  reg [CNT_W-1:0] incr;
  reg [31:0] rd_d;
  wire frame_err_count_nonzero;
  wire [15:0] change_one;
  wire [7:0] idx;
  wire req;
  wire wr;
  wire [15:0] wdat;
  wire [15:0] w1c_one;
  wire [15:0] w1c_two;
  wire [15:0] set_two;
  wire [1:0] count_type_select;
  wire qualify_ok;

  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign idx = wb_adr_in[9:2];
  assign wr = req & wb_we_in;
  // 16-bit registers sit in lanes 0 and 1
  assign wdat = {wb_sel_in[1] ? wb_dat_in[15:8] : 8'h00, wb_sel_in[0] ? wb_dat_in[7:0] : 8'h00};
  assign count_type_select = control_q[`E3RX_B_CTYPE_HI:`E3RX_B_CTYPE_LO];

  always @* begin
    status_one_d = 16'h0000;
    status_one_d[`E3RX_B_SIG_LOSS] = los_sync_q;
    status_one_d[`E3RX_B_OUT_FRAME] = out_frame_in;
    status_one_d[`E3RX_B_ALARM_SIG] = alarm_signal_in;
    status_one_d[`E3RX_B_REMOTE_ALARM] = remote_alarm_in;
    status_one_d[`E3RX_B_FRAME_LOSS] = frame_loss_in;
    status_one_d[`E3RX_B_N_BIT] = integrated_n_bit_in;
    status_one_d[`E3RX_B_A_BIT] = integrated_a_bit_in;
    status_one_d[`E3RX_B_UNFRAMED_ONES] = unframed_all_ones_state_in;
  end

  assign change_one = (status_one_d ^ status_one_q) & `E3RX_LATCH_ONE_MASK;

  assign frame_err_count_nonzero = |tally_q;

  assign qualify_ok = control_q[`E3RX_B_COUNT_ALWAYS] | ~(out_frame_in | alarm_signal_in);

  always @* begin
    incr = {CNT_W{1'b0}};
    case (count_type_select)
      `E3RX_CT_OUT_FRAME: incr = {{(CNT_W-1){1'b0}}, out_frame_in & ~status_one_q[`E3RX_B_OUT_FRAME]};
      `E3RX_CT_FAS_BIT: incr = qualify_ok ? {{(CNT_W-FAS_BITS_W){1'b0}}, fas_bit_errors_in} : {CNT_W{1'b0}};
      `E3RX_CT_FAS_WORD: incr = {{(CNT_W-1){1'b0}}, qualify_ok & framing_error_in};
      default: incr = {CNT_W{1'b0}};
    endcase
  end

  always @* begin
    accum_d = perf_monitor_update_in ? {CNT_W{1'b0}} : accum_q;
    if ({1'b0, accum_d} + {1'b0, incr} > {1'b0, CNT_MAX}) begin
      accum_d = CNT_MAX;
    end else begin
      accum_d = accum_d + incr;
    end
  end

  assign w1c_one = (wr && idx == `E3RX_IDX_LATCH_ONE) ? wdat : 16'h0000;
  assign w1c_two = (wr && idx == `E3RX_IDX_LATCH_TWO) ? wdat : 16'h0000;
  assign set_two = {7'h00, framing_error_in, 7'h00, frame_err_count_nonzero & ~nonzero_prev_q};

  always @(posedge ref_clk_in) begin
    los_meta_q <= line_signal_loss_input_in;
    los_sync_q <= los_meta_q;
    if (!nrst_in) begin
      los_meta_q <= 1'b0;
      los_sync_q <= 1'b0;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      status_one_q <= `E3RX_RESET_16;
      latch_one_q <= `E3RX_RESET_16;
      latch_two_q <= `E3RX_RESET_16;
      nonzero_prev_q <= 1'b0;
      accum_q <= {CNT_W{1'b0}};
      tally_q <= {CNT_W{1'b0}};
    end else begin
      status_one_q <= status_one_d;
      nonzero_prev_q <= frame_err_count_nonzero;
      accum_q <= accum_d;
      if (perf_monitor_update_in) begin
        tally_q <= accum_q;
      end
      // sticky, set wins over clear; alignment change
      latch_one_q <= ((latch_one_q & ~w1c_one) | change_one
                     | ((alignment_reload_in & alignment_differs_in) ? 16'h0020 : 16'h0000))
                     & `E3RX_LATCH_ONE_MASK;
      latch_two_q <= ((latch_two_q & ~w1c_two) | set_two) & `E3RX_LATCH_TWO_MASK;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      irq_en_one_q <= `E3RX_RESET_16;
      irq_en_two_q <= `E3RX_RESET_16;
      control_q <= `E3RX_RESET_16;
      global_en_q <= 1'b0;
    end else if (wr) begin
      case (idx)
        `E3RX_IDX_IRQEN_ONE: irq_en_one_q <= wdat & `E3RX_LATCH_ONE_MASK;
        `E3RX_IDX_IRQEN_TWO: irq_en_two_q <= wdat & `E3RX_LATCH_TWO_MASK;
        `E3RX_IDX_CONTROL: control_q <= wdat & `E3RX_CONTROL_MASK;
        `E3RX_IDX_GLOBAL_EN: global_en_q <= wdat[0];
        default: global_en_q <= global_en_q;
      endcase
    end
  end

  always @* begin
    rd_d = 32'h0000_0000;
    case (idx)
      `E3RX_IDX_STATUS_ONE: rd_d = {16'h0000, status_one_q};
      `E3RX_IDX_STATUS_TWO: rd_d = {31'h0000_0000, frame_err_count_nonzero};
      `E3RX_IDX_LATCH_ONE: rd_d = {16'h0000, latch_one_q};
      `E3RX_IDX_LATCH_TWO: rd_d = {16'h0000, latch_two_q};
      `E3RX_IDX_IRQEN_ONE: rd_d = {16'h0000, irq_en_one_q};
      `E3RX_IDX_IRQEN_TWO: rd_d = {16'h0000, irq_en_two_q};
      `E3RX_IDX_FE_COUNT: rd_d = {{(32-CNT_W){1'b0}}, tally_q};
      `E3RX_IDX_CONTROL: rd_d = {16'h0000, control_q};
      `E3RX_IDX_GLOBAL_EN: rd_d = {31'h0000_0000, global_en_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // unmapped reads answer zero with ack; writes there are dropped
  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      port_irq_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rd_d : 32'h0000_0000;
      port_irq_out <= global_en_q & (|(latch_one_q & irq_en_one_q) | |(latch_two_q & irq_en_two_q));
    end
  end

endmodule // e3rx_status_irq_bank
`default_nettype wire

// ===== verif/e3rx_bank_properties.sv
// checker for the e3 rx status bank bus and interrupt output
// assumes bound to the bank top, single clock domain
`include "e3rx_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module e3rx_bank_props (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic line_signal_loss_input_in,
  input wire logic out_frame_in,
  input wire logic port_irq_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence req(logic w, logic [7:0] i);
    wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in == w && wb_adr_in[9:2] == i;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("data without ack");
  AST_UNMAPPED: assert property (req(1'b0, 8'h3c) |=> wb_dat_out == 32'h0) else $error("unmapped read");
  AST_STATUS_TWO: assert property (
    req(1'b0, `E3RX_IDX_STATUS_TWO) |=> wb_dat_out[31:1] == 31'h0) else $error("status two bits");
  AST_OOF: assert property (
    $stable(out_frame_in)[*3] ##0 req(1'b0, `E3RX_IDX_STATUS_ONE) |=> wb_dat_out[1] == $past(out_frame_in))
    else $error("oof status");
  AST_LOS: assert property (
    $stable(line_signal_loss_input_in)[*6] ##0 req(1'b0, `E3RX_IDX_STATUS_ONE)
    |=> wb_dat_out[0] == $past(line_signal_loss_input_in)) else $error("los status");
  AST_GLOBAL_OFF: assert property (
    req(1'b1, `E3RX_IDX_GLOBAL_EN) ##0 !wb_dat_in[0] |=> ##1 !port_irq_out[*2]) else $error("irq while off");
endmodule // e3rx_bank_props
bind e3rx_status_irq_bank e3rx_bank_props u_props (.ref_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .line_signal_loss_input_in,
  .out_frame_in, .port_irq_out);
`default_nettype wire

// ===== verif/e3rx_fp_model.sv
// receive frame processor stand-in
// assumes one command word per cycle from the bench, zero when idle
`timescale 1ns/1ps
`default_nettype none
module e3rx_fp_model (
  input wire logic clk_in,
  input wire logic [15:0] cmd_in,
  output logic [7:0] lvl_out,
  output logic [3:0] pls_out,
  output logic [3:0] fbits_out
);
  initial lvl_out = 8'h00;
  // levels toggle so each command is exactly one change
  always @(posedge clk_in) begin
    lvl_out <= lvl_out ^ cmd_in[7:0];
    pls_out <= cmd_in[11:8];
    fbits_out <= cmd_in[15:12];
  end
endmodule // e3rx_fp_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the e3 rx status and irq bank
// assumes the frame processor model drives all condition inputs
`include "e3rx_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] l1 = `E3RX_IDX_LATCH_ONE, l2 = `E3RX_IDX_LATCH_TWO, fc = `E3RX_IDX_FE_COUNT;
  localparam logic [7:0] ct = `E3RX_IDX_CONTROL, ge = `E3RX_IDX_GLOBAL_EN, s2 = `E3RX_IDX_STATUS_TWO;
  logic ref_clk, nrst, cyc, stb, we, ack, irq;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] cmd, q;
  logic [7:0] lv;
  logic [3:0] pl, fb;
  integer n_errors = 0, samples_checked = 0, seed = 37, n, i;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  e3rx_fp_model fp_u (.clk_in(ref_clk), .cmd_in(cmd), .lvl_out(lv), .pls_out(pl), .fbits_out(fb));
  e3rx_status_irq_bank dut_u (.ref_clk_in(ref_clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .line_signal_loss_input_in(lv[0]), .out_frame_in(lv[1]), .alarm_signal_in(lv[2]), .remote_alarm_in(lv[3]),
    .frame_loss_in(lv[4]), .unframed_all_ones_state_in(lv[5]), .integrated_a_bit_in(lv[6]),
    .integrated_n_bit_in(lv[7]), .alignment_reload_in(pl[0]), .alignment_differs_in(pl[1]),
    .framing_error_in(pl[2]), .fas_bit_errors_in(fb), .perf_monitor_update_in(pl[3]), .port_irq_out(irq));
  function automatic logic [15:0] st1(input logic [7:0] v);
    st1 = {7'h0, v[5], v[6], v[7], 1'b0, v[4:0]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    integer k;
    @(posedge ref_clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {a, 2'b00};
    wdat <= {16'h0, d};
    k = 0;
    do begin
      @(posedge ref_clk);
      k = k + 1;
    end while (ack !== 1'b1 && k < 40);
    if (ack !== 1'b1) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t no ack", $time);
    end
    q = rdat[15:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0);
    chk(q, e);
  endtask
  task automatic ev(input logic [15:0] c);
    @(posedge ref_clk);
    cmd <= c;
    @(posedge ref_clk);
    cmd <= 16'h0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    {nrst, cyc, stb, we} = 4'h0;
    adr = 10'h0;
    wdat = 32'h0;
    cmd = 16'h0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`E3RX_IDX_IRQEN_TWO, 16'h0);
    rd(fc, 16'h0);
    rd(8'h3c, 16'h0);
    n = $random(seed) & `E3RX_LATCH_ONE_MASK;
    wb(1'b1, `E3RX_IDX_IRQEN_ONE, n[15:0]);
    rd(`E3RX_IDX_IRQEN_ONE, n[15:0]);
    for (i = 0; i < 8; i = i + 1) begin
      wb(1'b1, l1, 16'hffff);
      ev({8'h0, 8'h1 << i});
      rd(`E3RX_IDX_STATUS_ONE, st1(lv));
      rd(l1, st1(8'h1 << i));
      wb(1'b1, l1, st1(8'h1 << i));
      rd(l1, 16'h0);
      ev({8'h0, 8'h1 << i});
    end
    wb(1'b1, l1, 16'hffff);
    ev(16'h0100);
    rd(l1, 16'h0);
    ev(16'h0300);
    rd(l1, 16'h0020);
    wb(1'b1, ct, 16'h0200);
    // flush oof edges counted in the loop, then return the readable count to zero
    ev(16'h0800);
    ev(16'h0800);
    wb(1'b1, l2, 16'hffff);
    n = 1 + ($unsigned($random(seed)) % 5);
    repeat (n) ev(16'h0400);
    rd(fc, 16'h0);
    rd(l2, 16'h0100);
    ev(16'h0800);
    rd(fc, n[15:0]);
    rd(s2, 16'h0001);
    rd(l2, 16'h0101);
    ev(16'h0002);
    repeat (3) ev(16'h0400);
    ev(16'h0800);
    rd(fc, 16'h0);
    rd(s2, 16'h0);
    wb(1'b1, ct, 16'h0500);
    n = 1 + ($unsigned($random(seed)) % 10);
    ev({n[3:0], 12'h800});
    ev(16'h0800);
    rd(fc, n[15:0]);
    wb(1'b1, ct, 16'h0000);
    ev(16'h0002);
    ev(16'h0002);
    ev(16'h0800);
    rd(fc, 16'h0001);
    wb(1'b1, l1, 16'hffff);
    wb(1'b1, l2, 16'hffff);
    wb(1'b1, `E3RX_IDX_IRQEN_ONE, 16'h0001);
    wb(1'b1, ge, 16'h0001);
    ev(16'h0001);
    chk({15'h0, irq}, 16'h1);
    wb(1'b1, ge, 16'h0000);
    repeat (2) @(posedge ref_clk);
    chk({15'h0, irq}, 16'h0);
    wb(1'b1, ge, 16'h0001);
    wb(1'b1, l1, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk({15'h0, irq}, 16'h0);
    wb(1'b1, `E3RX_IDX_IRQEN_TWO, 16'h0100);
    ev(16'h0400);
    chk({15'h0, irq}, 16'h1);
    close_out;
  end
endmodule // tb_top
`default_nettype wire
